/* shared/pfp_pkg.sv */
// Package: constants and types for the parallel FIFO pipeline status and run-length block
`default_nettype none
package pfp_pkg;
    // Register offsets on the local register port
    localparam logic [7:0] OFS_PORT_CTRL = 8'h31;
    localparam logic [7:0] OFS_STATUS = 8'h32;
    localparam logic [7:0] OFS_THRESHOLD = 8'h33;
    localparam logic [7:0] OFS_FIFO_CTRL = 8'h34;
    localparam logic [7:0] OFS_HOLD1 = 8'h35;
    localparam logic [7:0] OFS_HOLD2 = 8'h36;
    localparam logic [7:0] OFS_RUN_COUNT = 8'h37;
    // Field positions in the FIFO control register
    localparam int FC_FIFO_RESET = 0;
    localparam int FC_DMA_EN = 1;
    localparam int FC_TAG_IRQ_EN = 2;
    localparam int FC_RLE_EN = 3;
    localparam int FC_DIR = 4;
    // Field position in the port control register
    localparam int PC_CLR_TIMEOUT = 3;
    // Values after reset
    localparam logic [7:0] STATUS_RESET = 8'h40;
    localparam logic [7:0] FIFO_CTRL_RESET = 8'h00;
    localparam logic [7:0] PORT_CTRL_RESET = 8'h00;
    localparam logic [6:0] THRESHOLD_RESET = 7'h00;
    localparam logic [6:0] RUN_COUNT_RESET = 7'h00;
    // Counts
    localparam logic [6:0] QTY_MAX = 7'h40;
    localparam logic [6:0] RUN_MAX = 7'h7f;
    localparam logic [6:0] RUN_MIN = 7'h03;
    localparam logic [6:0] QTY_DRAINED = 7'h01;
    // Transmit run-length encoder states
    typedef enum logic [3:0] {
        ENC_IDLE = 4'b0001,
        ENC_HOLD = 4'b0010,
        ENC_CODE = 4'b0100,
        ENC_BYTE = 4'b1000
    } pfp_enc_state_t;
    // Status register layout, bit 7 first
    typedef struct packed {
        logic fifo_full;
        logic fifo_empty;
        logic timeout;
        logic holding_tag;
        logic holding_data;
        logic stale;
        logic single_leftover;
        logic data_error;
    } pfp_status_t;
    // One byte of the ECP stream: cmd marks a tagged byte
    typedef struct packed {
        logic cmd;
        logic [7:0] data;
    } pfp_byte_t;
endpackage
`default_nettype wire

/* logic/pfp_status_rle.sv */
// Parallel FIFO pipeline status, DMA threshold and run-length coding logic
// Function
// - Status bits 7/6 show FIFO full/empty
// - Status not latched; timeout and holding bits come from registers
// - Timeout sets on stale rise; receive waits drain
// - Timeout sticky until toggle clear or reset
// - Tag bit while holding byte tagged; interrupts
// - Holding-data bit when either holding register full
// - Stale with one byte: interrupt, block refill
// - Stale with two bytes: DMA request, no interrupt
// - One-character bit: empty, stale, one byte
// - DMA moves bytes, stops at one; software takes odd byte
// - Data-error bit is OR of error register
// - Threshold is seven bits, bit 7 zero
// - Threshold reached holds DMA request until drained
// - Receive holding registers fill before quantity counts
// - Threshold cleared by device reset only
// - Run-length only with enable and ECP mode
// - Transmit counts runs, emits count then byte
// - Run count is seven bits, bit 7 zero
// - Receive code loads count, repeats next byte
// - Disabled codes enter pipeline tagged, host removes
// - Run count cleared by device or FIFO reset
// - Direction one transmits, zero receives
// - Quantity counts data or space, excludes pipeline
`default_nettype none
module pfp_status_rle (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [6:0] fifo_quantity,
    input wire logic fifo_full_flag,
    input wire logic fifo_empty_flag,
    input wire logic stale_flag,
    input wire logic [7:0] data_error_register,
    input wire logic ecp_mode,
    input wire pfp_pkg::pfp_byte_t fifo_out,
    input wire logic fifo_out_valid,
    output logic fifo_out_ready,
    input wire logic [7:0] tx_in_data,
    input wire logic tx_in_valid,
    output logic tx_in_ready,
    input wire logic tx_burst_end,
    output pfp_pkg::pfp_byte_t fifo_in,
    output logic fifo_in_valid,
    input wire logic fifo_in_ready,
    input wire logic dma_ack,
    output logic [7:0] dma_rdata,
    output logic dma_request,
    output logic pipeline_irq,
    output logic fifo_reset_pulse,
    output logic transfer_direction_bit,
    output logic dma_enable_bit,
    output logic run_length_enable
);
    logic [7:0] fifo_ctrl_reg;
    logic [7:0] port_ctrl_reg;
    logic [6:0] threshold_reg;
    logic [6:0] run_count_reg;
    logic fifo_reset_reg;
    pfp_pkg::pfp_byte_t hold1_reg;
    pfp_pkg::pfp_byte_t hold2_reg;
    logic hold1_full_reg;
    logic hold2_full_reg;
    logic expanding_reg;
    logic stale_d_reg;
    logic timeout_pending_reg;
    logic timeout_reg;
    logic block_reg;
    logic stale_dma_reg;
    logic thresh_active_reg;
    logic dma_request_reg;
    logic [7:0] reg_rdata_reg;
    logic [7:0] dma_rdata_reg;
    pfp_pkg::pfp_enc_state_t enc_state_reg;
    logic [7:0] held_byte_reg;
    logic [7:0] next_byte_reg;
    logic have_next_reg;
    pfp_pkg::pfp_byte_t fifo_in_reg;
    logic fifo_in_valid_reg;
    pfp_pkg::pfp_status_t status;
    logic is_tx;
    logic rle_active;
    logic is_code;
    logic wr_fifo_ctrl;
    logic clr_timeout;
    logic pop1;
    logic pop2;
    logic move12;
    logic hold1_stays;
    logic hold1_frees;
    logic take_code;
    logic take_byte;
    logic stale_rise;
    logic [7:0] pipe_total;
    logic one_left;
    logic tag_flag;
    logic dma_request_next;
    logic can_emit;
    logic tx_take;
    logic run_extends;

    // Read-only field extraction from stored control bits
    function automatic logic bit_of(input logic [7:0] r, input int pos);
        return r[pos];
    endfunction

    // Control bits driving the engine and the rest of this block
    assign transfer_direction_bit = bit_of(fifo_ctrl_reg, pfp_pkg::FC_DIR);
    assign dma_enable_bit = bit_of(fifo_ctrl_reg, pfp_pkg::FC_DMA_EN);
    assign run_length_enable = bit_of(fifo_ctrl_reg, pfp_pkg::FC_RLE_EN);
    assign fifo_reset_pulse = fifo_reset_reg;
    assign is_tx = transfer_direction_bit;
    assign rle_active = run_length_enable && ecp_mode;
    assign is_code = fifo_out.cmd && !fifo_out.data[7];
    assign wr_fifo_ctrl = reg_wr && (reg_addr == pfp_pkg::OFS_FIFO_CTRL);
    // Toggling the clear bit in either direction clears timeout
    assign clr_timeout = reg_wr && (reg_addr == pfp_pkg::OFS_PORT_CTRL)
                         && (reg_wdata[pfp_pkg::PC_CLR_TIMEOUT] != port_ctrl_reg[pfp_pkg::PC_CLR_TIMEOUT]);

    // Control registers; the threshold survives a FIFO reset
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            fifo_ctrl_reg <= pfp_pkg::FIFO_CTRL_RESET;
            port_ctrl_reg <= pfp_pkg::PORT_CTRL_RESET;
            threshold_reg <= pfp_pkg::THRESHOLD_RESET;
            fifo_reset_reg <= 1'b0;
        end else if (ce) begin
            fifo_reset_reg <= wr_fifo_ctrl && reg_wdata[pfp_pkg::FC_FIFO_RESET];
            if (wr_fifo_ctrl) begin
                fifo_ctrl_reg <= {reg_wdata[7:1], 1'b0};
            end
            if (reg_wr && reg_addr == pfp_pkg::OFS_PORT_CTRL) begin
                port_ctrl_reg <= reg_wdata;
            end
            if (reg_wr && reg_addr == pfp_pkg::OFS_THRESHOLD) begin
                threshold_reg <= reg_wdata[6:0];
            end
        end
    end

    // Receive pipeline moves: host reads pop either stage, DMA pops only the second
    assign pop1 = !is_tx && hold1_full_reg && reg_rd && (reg_addr == pfp_pkg::OFS_HOLD1);
    assign pop2 = !is_tx && hold2_full_reg && ((reg_rd && reg_addr == pfp_pkg::OFS_HOLD2)
                  || (dma_ack && !hold2_reg.cmd));
    assign move12 = !is_tx && hold1_full_reg && (!hold2_full_reg || pop2) && !pop1;
    assign hold1_stays = move12 && expanding_reg && (run_count_reg != 7'h00);
    assign hold1_frees = !hold1_full_reg || pop1 || (move12 && !hold1_stays);
    // A code waits for a running expansion and an empty first stage, else a stale byte would be repeated
    assign take_code = !is_tx && !block_reg && fifo_out_valid && is_code && rle_active && !expanding_reg
                       && hold1_frees;
    assign take_byte = !is_tx && !block_reg && fifo_out_valid && !(is_code && rle_active) && hold1_frees;
    assign fifo_out_ready = take_code || take_byte;

    // Holding registers fill ahead of the FIFO quantity count
    always_ff @(posedge clk_sys) begin
        if (!rstn || fifo_reset_reg) begin
            hold1_reg <= '0;
            hold2_reg <= '0;
            hold1_full_reg <= 1'b0;
            hold2_full_reg <= 1'b0;
        end else if (ce) begin
            if (move12) begin
                hold2_reg <= hold1_reg;
                hold2_full_reg <= 1'b1;
            end else if (pop2) begin
                hold2_full_reg <= 1'b0;
            end
            if (take_byte) begin
                hold1_reg <= fifo_out;
                hold1_full_reg <= 1'b1;
            end else if (hold1_frees) begin
                hold1_full_reg <= 1'b0;
            end
        end
    end

    // Run count: receive expansion and transmit run tracking share it
    always_ff @(posedge clk_sys) begin
        if (!rstn || fifo_reset_reg) begin
            run_count_reg <= pfp_pkg::RUN_COUNT_RESET;
            expanding_reg <= 1'b0;
        end else if (ce) begin
            if (reg_wr && reg_addr == pfp_pkg::OFS_RUN_COUNT) begin
                run_count_reg <= reg_wdata[6:0];
            end else if (take_code) begin
                run_count_reg <= fifo_out.data[6:0];
                expanding_reg <= 1'b1;
            end else if (hold1_stays) begin
                run_count_reg <= run_count_reg - 7'h01;
            end else if (move12 && expanding_reg) begin
                expanding_reg <= 1'b0;
            end else if (is_tx && tx_take) begin
                run_count_reg <= (enc_state_reg == pfp_pkg::ENC_HOLD && run_extends)
                                 ? run_count_reg + 7'h01 : (enc_state_reg == pfp_pkg::ENC_HOLD)
                                 ? run_count_reg : 7'h01;
            end else if (is_tx && can_emit && enc_state_reg == pfp_pkg::ENC_CODE) begin
                run_count_reg <= 7'h01;
            end else if (is_tx && can_emit && enc_state_reg == pfp_pkg::ENC_BYTE) begin
                run_count_reg <= (run_count_reg == 7'h01) ? {6'h00, have_next_reg} : run_count_reg - 7'h01;
            end
        end
    end

    // Transmit encoder: a run of three or more leaves as count code then one byte
    assign can_emit = !fifo_in_valid_reg || fifo_in_ready;
    assign run_extends = (tx_in_data == held_byte_reg) && (run_count_reg < pfp_pkg::RUN_MAX);
    assign tx_in_ready = is_tx && (enc_state_reg == pfp_pkg::ENC_IDLE
                         || (enc_state_reg == pfp_pkg::ENC_HOLD && !have_next_reg));
    assign tx_take = tx_in_ready && tx_in_valid;
    always_ff @(posedge clk_sys) begin
        if (!rstn || fifo_reset_reg) begin
            enc_state_reg <= pfp_pkg::ENC_IDLE;
            held_byte_reg <= 8'h00;
            next_byte_reg <= 8'h00;
            have_next_reg <= 1'b0;
            fifo_in_reg <= '0;
            fifo_in_valid_reg <= 1'b0;
        end else if (ce) begin
            if (fifo_in_ready) begin
                fifo_in_valid_reg <= 1'b0;
            end
            case (enc_state_reg)
                pfp_pkg::ENC_IDLE: begin
                    if (tx_take) begin
                        held_byte_reg <= tx_in_data;
                        enc_state_reg <= rle_active ? pfp_pkg::ENC_HOLD : pfp_pkg::ENC_BYTE;
                    end
                end
                pfp_pkg::ENC_HOLD: begin
                    // A different byte or the burst end closes the run
                    if ((tx_take && !run_extends) || (!tx_take && tx_burst_end)) begin
                        enc_state_reg <= (run_count_reg >= pfp_pkg::RUN_MIN) ? pfp_pkg::ENC_CODE
                                                                              : pfp_pkg::ENC_BYTE;
                        if (tx_take) begin
                            next_byte_reg <= tx_in_data;
                            have_next_reg <= 1'b1;
                        end
                    end
                end
                pfp_pkg::ENC_CODE: begin
                    if (can_emit) begin
                        fifo_in_reg <= '{cmd: 1'b1, data: {1'b0, run_count_reg - 7'h01}};
                        fifo_in_valid_reg <= 1'b1;
                        enc_state_reg <= pfp_pkg::ENC_BYTE;
                    end
                end
                pfp_pkg::ENC_BYTE: begin
                    if (can_emit) begin
                        fifo_in_reg <= '{cmd: 1'b0, data: held_byte_reg};
                        fifo_in_valid_reg <= 1'b1;
                        if (run_count_reg == 7'h01) begin
                            if (have_next_reg) begin
                                held_byte_reg <= next_byte_reg;
                                have_next_reg <= 1'b0;
                                enc_state_reg <= rle_active ? pfp_pkg::ENC_HOLD : pfp_pkg::ENC_BYTE;
                            end else begin
                                enc_state_reg <= pfp_pkg::ENC_IDLE;
                            end
                        end
                    end
                end
                default: begin
                    enc_state_reg <= pfp_pkg::ENC_IDLE;
                end
            endcase
        end
    end
    assign fifo_in = fifo_in_reg;
    assign fifo_in_valid = fifo_in_valid_reg;

    // Pipeline occupancy; in receive the quantity counts data bytes
    assign pipe_total = {1'b0, fifo_quantity} + {7'h00, hold1_full_reg} + {7'h00, hold2_full_reg};
    assign one_left = !is_tx && (pipe_total == 8'h01);
    assign stale_rise = stale_flag && !stale_d_reg;
    assign tag_flag = (hold1_full_reg && hold1_reg.cmd) || (hold2_full_reg && hold2_reg.cmd);

    // Stale handling: one byte blocks refill, two or more ask for DMA
    always_ff @(posedge clk_sys) begin
        if (!rstn || fifo_reset_reg) begin
            stale_d_reg <= 1'b0;
            block_reg <= 1'b0;
            stale_dma_reg <= 1'b0;
        end else if (ce) begin
            stale_d_reg <= stale_flag;
            if (stale_rise && one_left) begin
                block_reg <= 1'b1;
            end else if (!hold2_full_reg) begin
                block_reg <= 1'b0;
            end
            if (stale_rise && !is_tx && pipe_total >= 8'h02) begin
                stale_dma_reg <= 1'b1;
            end else if (pipe_total < 8'h02 || is_tx) begin
                stale_dma_reg <= 1'b0;
            end
        end
    end

    // Timeout: set beats clear; receive waits for FIFO empty and DMA idle
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            timeout_pending_reg <= 1'b0;
            timeout_reg <= 1'b0;
        end else if (ce) begin
            if (timeout_pending_reg && (is_tx || (fifo_empty_flag && !dma_request_reg && !dma_ack))) begin
                timeout_pending_reg <= stale_rise;
                timeout_reg <= 1'b1;
            end else begin
                if (stale_rise) begin
                    timeout_pending_reg <= 1'b1;
                end else if (fifo_reset_reg) begin
                    timeout_pending_reg <= 1'b0;
                end
                if (clr_timeout || fifo_reset_reg) begin
                    timeout_reg <= 1'b0;
                end
            end
        end
    end

    // DMA request: threshold reached holds until the quantity drains to one byte or less
    always_comb begin
        dma_request_next = 1'b0;
        if (dma_enable_bit && !tag_flag) begin
            dma_request_next = (thresh_active_reg || stale_dma_reg) && (is_tx || hold2_full_reg);
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rstn || fifo_reset_reg) begin
            thresh_active_reg <= 1'b0;
            dma_request_reg <= 1'b0;
        end else if (ce) begin
            dma_request_reg <= dma_request_next;
            if (!dma_enable_bit) begin
                thresh_active_reg <= 1'b0;
            end else if (fifo_quantity >= threshold_reg && fifo_quantity > pfp_pkg::QTY_DRAINED) begin
                thresh_active_reg <= 1'b1;
            end else if (fifo_quantity <= pfp_pkg::QTY_DRAINED) begin
                thresh_active_reg <= 1'b0;
            end
        end
    end
    assign dma_request = dma_request_reg;

    // Live status; timeout and holding bits come from registers that reset clears, so reset shows only the empty flag
    always_comb begin
        status.fifo_full = fifo_full_flag;
        status.fifo_empty = fifo_empty_flag;
        status.timeout = timeout_reg;
        status.holding_tag = tag_flag;
        status.holding_data = hold1_full_reg || hold2_full_reg;
        status.stale = stale_flag;
        status.single_leftover = !is_tx && fifo_empty_flag && stale_flag
                                 && hold2_full_reg && !hold1_full_reg;
        status.data_error = |data_error_register;
    end

    // Pipeline interrupt: timeout, enabled tag, or the lone stale byte
    assign pipeline_irq = timeout_reg || status.single_leftover
                          || (tag_flag && bit_of(fifo_ctrl_reg, pfp_pkg::FC_TAG_IRQ_EN));

    // Read data one cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            reg_rdata_reg <= 8'h00;
            dma_rdata_reg <= 8'h00;
        end else if (ce) begin
            if (pop2 && dma_ack) begin
                dma_rdata_reg <= hold2_reg.data;
            end
            if (reg_rd) begin
                case (reg_addr)
                    pfp_pkg::OFS_STATUS: reg_rdata_reg <= status;
                    pfp_pkg::OFS_THRESHOLD: reg_rdata_reg <= {1'b0, threshold_reg};
                    pfp_pkg::OFS_RUN_COUNT: reg_rdata_reg <= {1'b0, run_count_reg};
                    pfp_pkg::OFS_FIFO_CTRL: reg_rdata_reg <= fifo_ctrl_reg;
                    pfp_pkg::OFS_PORT_CTRL: reg_rdata_reg <= port_ctrl_reg;
                    pfp_pkg::OFS_HOLD1: reg_rdata_reg <= hold1_reg.data;
                    pfp_pkg::OFS_HOLD2: reg_rdata_reg <= hold2_reg.data;
                    default: reg_rdata_reg <= 8'h00;
                endcase
            end else begin
                reg_rdata_reg <= 8'h00;
            end
        end
    end
    assign reg_rdata = reg_rdata_reg;
    assign dma_rdata = dma_rdata_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence seq_status_read;
        ce && reg_rd && reg_addr == pfp_pkg::OFS_STATUS;
    endsequence
    sequence seq_code_taken;
        ce && take_code && fifo_out_valid && !fifo_reset_reg && !(reg_wr && reg_addr == pfp_pkg::OFS_RUN_COUNT);
    endsequence

    AST_FULL_EMPTY_READ: assert property (seq_status_read |=> reg_rdata[7] == $past(fifo_full_flag)
        && reg_rdata[6] == $past(fifo_empty_flag)) else $error("full or empty bit wrong");
    AST_HOLD_DATA_READ: assert property (seq_status_read |=> reg_rdata[3] == $past(hold1_full_reg || hold2_full_reg))
        else $error("holding data bit wrong");
    AST_ERROR_READ: assert property (seq_status_read |=> reg_rdata[0] == $past(|data_error_register))
        else $error("data error bit wrong");
    AST_THRESHOLD_MSB: assert property (ce && reg_rd && reg_addr == pfp_pkg::OFS_THRESHOLD |=> !reg_rdata[7])
        else $error("threshold bit 7 not zero");
    AST_TIMEOUT_STICKY: assert property (ce && timeout_reg && !clr_timeout && !fifo_reset_reg |=> timeout_reg)
        else $error("timeout dropped without clear");
    AST_DMA_NEEDS_ENABLE: assert property (ce && !dma_enable_bit |=> !dma_request)
        else $error("DMA request without enable");
    AST_BLOCK_REFILL: assert property (ce && stale_rise && one_left && !fifo_reset_reg
        |=> block_reg && !fifo_out_ready) else $error("refill not blocked");
    AST_CODE_LOADS_COUNT: assert property (seq_code_taken |=> run_count_reg == $past(fifo_out.data[6:0])
        && expanding_reg) else $error("run code not captured");
    AST_RUN_CLEAR: assert property (ce && fifo_reset_reg |=> run_count_reg == 7'h00)
        else $error("run count not cleared");
    AST_CODE_EMIT: assert property (ce && enc_state_reg == pfp_pkg::ENC_CODE && can_emit && !fifo_reset_reg
        |=> fifo_in_valid && fifo_in.cmd && enc_state_reg == pfp_pkg::ENC_BYTE) else $error("run code not emitted");
endmodule
`default_nettype wire

/* verif/pfp_dma_host_model.sv */
// Host-side DMA controller model that acknowledges one byte at a time
`default_nettype none
module pfp_dma_host_model (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic dma_request,
    input wire logic slow,
    input wire logic [7:0] dma_rdata,
    output logic dma_ack,
    output logic got_v,
    output logic [7:0] got
);
    logic ack_d_reg;
    logic [2:0] gap_reg;
    // One-cycle ack, then a pause so a request that is about to fall is not acked twice
    always_ff @(posedge clk_sys) begin
        ack_d_reg <= dma_ack;
        got_v <= ack_d_reg;
        got <= dma_rdata; // Read data stand in the cycle after the ack
        if (!rstn || dma_ack) begin
            dma_ack <= 1'b0;
            gap_reg <= slow ? 3'h5 : 3'h1;
        end else if (gap_reg != 3'h0) gap_reg <= gap_reg - 3'h1;
        else dma_ack <= dma_request;
    end
endmodule
`default_nettype wire

/* verif/pfp_status_rle_tb.sv */
// Self-checking bench for the FIFO pipeline status and run-length block
`default_nettype none
module pfp_status_rle_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, rstn_n = 0, ce = 1, wr_s = 0, rd_s = 0, full = 0, empty = 1, stale = 0, ecp = 0, fo_v = 0;
    logic tx_v = 0, bend = 0, fi_rdy = 1, fo_rdy, tx_rdy, fi_v, ack, dreq, irq, frp, dir, dmae, rle, gv;
    logic [7:0] addr = 0, wd = 0, derr = 0, txd = 0, rdata, rv, drd, got, rnd;
    logic [6:0] qty = 0;
    logic [31:0] seed = 32'h34;
    pfp_pkg::pfp_byte_t fo = '0, fi;
    int failures = 0, compares = 0, cycles = 0;
    logic [7:0] q[$];
    always #25 clk_sys = ~clk_sys;
    pfp_status_rle pfp_status_rle_inst (.clk_sys(clk_sys), .rstn(rstn_n), .ce(ce), .reg_addr(addr), .reg_wdata(wd),
        .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata), .fifo_quantity(qty), .fifo_full_flag(full),
        .fifo_empty_flag(empty), .stale_flag(stale), .data_error_register(derr), .ecp_mode(ecp), .fifo_out(fo),
        .fifo_out_valid(fo_v), .fifo_out_ready(fo_rdy), .tx_in_data(txd), .tx_in_valid(tx_v), .tx_in_ready(tx_rdy),
        .tx_burst_end(bend), .fifo_in(fi), .fifo_in_valid(fi_v), .fifo_in_ready(fi_rdy), .dma_ack(ack),
        .dma_rdata(drd), .dma_request(dreq), .pipeline_irq(irq), .fifo_reset_pulse(frp),
        .transfer_direction_bit(dir), .dma_enable_bit(dmae), .run_length_enable(rle));
    pfp_dma_host_model pfp_dma_host_model_inst (.clk_sys(clk_sys), .rstn(rstn_n), .dma_request(dreq), .slow(1'b1),
        .dma_rdata(drd), .dma_ack(ack), .got_v(gv), .got(got));
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // Status as the live inputs say it should read
    function automatic logic [7:0] st(input logic to);
        return {full, empty, to, 2'b00, stale, 1'b0, |derr};
    endfunction
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Bus cycles end 1 ns after the taking edge so strobes never change twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a; wd <= d; wr_s <= 1'b1;
        @(posedge clk_sys);
        wr_s <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        addr <= a; rd_s <= 1'b1;
        @(posedge clk_sys);
        rd_s <= 1'b0;
        #1 rv = rdata;
    endtask
    task automatic end_of_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Hang guard and check of every byte the DMA model takes
    always @(posedge clk_sys) begin
        cycles++;
        if (gv === 1'b1) check("dma_byte", got, q.pop_front());
        if (cycles == 3000) begin
            failures++;
            end_of_test();
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rstn_n <= 1'b1;
        @(posedge clk_sys);
        rd(pfp_pkg::OFS_STATUS);
        check("status_rst", rv, 8'h40);
        rd(pfp_pkg::OFS_THRESHOLD);
        check("thr_rst", rv, 8'h00);
        repeat (4) begin
            rnd = xs();
            full <= rnd[0]; empty <= rnd[1]; derr <= rnd[2] ? xs() : 8'h00;
            rd(pfp_pkg::OFS_STATUS);
            check("status", rv, st(1'b0));
        end
        rnd = xs();
        wr(pfp_pkg::OFS_THRESHOLD, rnd);
        wr(pfp_pkg::OFS_RUN_COUNT, 8'hff);
        rd(pfp_pkg::OFS_RUN_COUNT);
        check("run_count", rv, 8'h7f);
        wr(pfp_pkg::OFS_FIFO_CTRL, 8'h01);
        repeat (2) @(posedge clk_sys);
        rd(pfp_pkg::OFS_RUN_COUNT);
        check("run_fres", rv, 8'h00);
        rd(pfp_pkg::OFS_THRESHOLD);
        check("thr_kept", rv, rnd & 8'h7f);
        $display("test registers done");
        wr(pfp_pkg::OFS_FIFO_CTRL, 8'h10);
        stale <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(pfp_pkg::OFS_STATUS);
        check("timeout_set", rv, st(1'b1));
        check("dir_irq", {6'h00, dir, irq}, 8'h03);
        stale <= 1'b0;
        rd(pfp_pkg::OFS_STATUS);
        check("timeout_held", rv, st(1'b1));
        wr(pfp_pkg::OFS_PORT_CTRL, 8'h08);
        rd(pfp_pkg::OFS_STATUS);
        check("timeout_clr", rv, st(1'b0));
        rnd = xs();
        txd <= rnd; tx_v <= 1'b1;
        do @(posedge clk_sys); while (tx_rdy !== 1'b1);
        tx_v <= 1'b0;
        do @(posedge clk_sys); while (fi_v !== 1'b1);
        check("tx_byte", fi.data, rnd);
        check("tx_cmd", {7'h00, fi.cmd}, 8'h00);
        // Four equal bytes then burst end: code of copies minus one, then the byte
        wr(pfp_pkg::OFS_FIFO_CTRL, 8'h18);
        ecp <= 1'b1;
        tx_v <= 1'b1;
        repeat (4) do @(posedge clk_sys); while (tx_rdy !== 1'b1);
        tx_v <= 1'b0;
        bend <= 1'b1;
        @(posedge clk_sys);
        bend <= 1'b0;
        do @(posedge clk_sys); while (fi_v !== 1'b1);
        check("rle_code", fi.data, 8'h03);
        check("rle_cmd", {7'h00, fi.cmd}, 8'h01);
        @(posedge clk_sys);
        check("rle_byte", fi.data, rnd);
        $display("test timeout and transmit done");
        wr(pfp_pkg::OFS_THRESHOLD, 8'h02);
        wr(pfp_pkg::OFS_FIFO_CTRL, 8'h02);
        repeat (2) begin
            rnd = xs();
            fo <= {1'b0, rnd}; fo_v <= 1'b1; q.push_back(rnd);
            do @(posedge clk_sys); while (fo_rdy !== 1'b1);
        end
        fo_v <= 1'b0;
        repeat (3) @(posedge clk_sys);
        check("dreq_low", {7'h00, dreq}, 8'h00);
        qty <= 7'h02;
        repeat (3) @(posedge clk_sys);
        check("dreq_high", {7'h00, dreq}, 8'h01);
        qty <= 7'h01;
        repeat (12) @(posedge clk_sys);
        check("dreq_fall", {7'h00, dreq}, 8'h00);
        // Odd byte left in the second stage goes stale: interrupt, then host read
        qty <= 7'h00;
        empty <= 1'b1;
        stale <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(pfp_pkg::OFS_STATUS);
        check("one_left", rv, st(1'b1) | 8'h0a);
        check("one_irq", {7'h00, irq}, 8'h01);
        rd(pfp_pkg::OFS_HOLD2);
        check("leftover", rv, q.pop_front());
        // Received code of one gives two copies of the next byte
        wr(pfp_pkg::OFS_FIFO_CTRL, 8'h09);
        repeat (2) @(posedge clk_sys);
        fo <= 9'h101;
        fo_v <= 1'b1;
        do @(posedge clk_sys); while (fo_rdy !== 1'b1);
        rnd = xs();
        fo <= {1'b0, rnd};
        do @(posedge clk_sys); while (fo_rdy !== 1'b1);
        fo_v <= 1'b0;
        repeat (2) @(posedge clk_sys);
        repeat (2) begin
            rd(pfp_pkg::OFS_HOLD2);
            check("rle_copy", rv, rnd);
        end
        rd(pfp_pkg::OFS_STATUS);
        check("rle_drained", rv & 8'h08, 8'h00);
        $display("test dma done");
        end_of_test();
    end
endmodule
`default_nettype wire
